//--- verilog/adc_ctrl_defs.svh
// Register offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// ==========================================================================
// Register offsets (byte addresses in the special-function space)
`define OFS_RESULT_LOW    8'h9B
`define OFS_RESULT_HIGH   8'h9C
`define OFS_CONTROL_A     8'h9D
`define OFS_CONTROL_B     8'h9E
`define OFS_TRIGGER_SEL   8'h9F
`define OFS_IRQ_STATUS    8'hA0
`define OFS_IRQ_ENABLE    8'hA1
`define OFS_IRQ_CLEAR     8'hA2

// ==========================================================================
// Field positions
`define CTLA_CHAN_MSB     7
`define CTLA_CHAN_LSB     2
`define CTLA_BUSY_BIT     1
`define CTLA_ENABLE_BIT   0
`define CTLB_FORMAT_BIT   7
`define CTLB_CLK_MSB      6
`define CTLB_CLK_LSB      4
`define CTLB_REF_MSB      1
`define CTLB_REF_LSB      0
`define TRIG_MSB          3
`define TRIG_LSB          0

// ==========================================================================
// Reset values
`define RST_CONTROL_A     8'h00
`define RST_CONTROL_B     8'h00
`define RST_TRIGGER_SEL   4'h0
`define RST_RESULT        16'h0000

// ==========================================================================
// Channel codes of note
`define CHAN_FIRST_PIN    6'h00
`define CHAN_GROUND       6'h24
`define CHAN_FIXED_REF    6'h25

// ==========================================================================
// Trigger codes
`define TRIG_NONE         4'h0
`define TRIG_PIN          4'h1
`define TRIG_IOC          4'h9
`define TRIG_RESULT_READ  4'hD

// ==========================================================================
// Timing: conversion length in conversion-clock periods
`define CONV_TICKS        8'd13
`endif

//--- verilog/adc_ctrl_pkg.sv
// Types shared by the converter control block
package adc_ctrl_pkg;

  typedef enum logic [1:0] {
    REF_SUPPLY,
    REF_EXT_PIN,
    REF_FIXED,
    REF_NONE
  } pos_ref_e;

  typedef struct packed {
    logic        enable;
    logic        start;
    logic [5:0]  channel;
    logic        channel_valid;
    pos_ref_e    pos_ref;
    logic        use_rc_clock;
  } core_ctrl_s;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_IDLE,
    ST_CONVERT
  } conv_state_e;

endpackage : adc_ctrl_pkg

//--- verilog/adc_control_register_logic.sv
// Control and result register logic of the analog-to-digital converter
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"

module adc_control_register_logic
  import adc_ctrl_pkg::*;
#(
  parameter int RESULT_BITS = 10
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_b,
  input  wire logic [7:0]       i_addr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic [7:0]            o_rdata,
  input  wire logic             i_rc_clock,
  input  wire logic [8:0]       i_trig_src,
  input  wire logic             i_core_done,
  input  wire logic [9:0]       i_core_data,
  output core_ctrl_s            o_core_ctrl,
  output logic                  o_conv_tick,
  output logic                  o_irq
);

  // ========================================================================
  // Elaboration check
  if (RESULT_BITS != 10) begin : g_bad_width
    $error("RESULT_BITS must be 10: justification forces exactly six zero bits");
  end
  // Trigger inputs: pin selector, three timers, two compares, two pulse outputs, change flag
  localparam int N_TRIG = 9;

  // ========================================================================
  // Register state
  logic [5:0]   chan_ff;
  logic         busy_ff;
  logic         enable_ff;
  logic         format_ff;
  logic [2:0]   clk_sel_ff;
  logic [1:0]   ref_sel_ff;
  logic [3:0]   trig_sel_ff;
  logic [15:0]  result_ff;
  logic         done_sts_ff;
  logic         done_en_ff;
  logic [7:0]   rdata_ff;
  logic         trig_prev_ff;
  logic [8:0]   trig_sync;
  logic [1:0]   rc_s1_ff;
  logic         rc_s2_ff;
  logic         rc_prev_ff;
  logic [5:0]   div_cnt_ff;
  conv_state_e  state_ff;
  conv_state_e  nxt_state;

  // ========================================================================
  // Address decode
  // One select per byte location of the register map
  wire sel_lo   = (i_addr == `OFS_RESULT_LOW);
  wire sel_hi   = (i_addr == `OFS_RESULT_HIGH);
  wire sel_a    = (i_addr == `OFS_CONTROL_A);
  wire sel_b    = (i_addr == `OFS_CONTROL_B);
  wire sel_trig = (i_addr == `OFS_TRIGGER_SEL);
  wire sel_sts  = (i_addr == `OFS_IRQ_STATUS);
  wire sel_en   = (i_addr == `OFS_IRQ_ENABLE);
  wire sel_clr  = (i_addr == `OFS_IRQ_CLEAR);
  wire wr_a     = i_wr & sel_a;

  // Read data mux; unmapped addresses read zero
  wire [7:0] rd_mux =
      sel_lo   ? result_ff[7:0] :
      sel_hi   ? result_ff[15:8] :
      sel_a    ? {chan_ff, busy_ff, enable_ff} :
      sel_b    ? {format_ff, clk_sel_ff, 2'b00, ref_sel_ff} :
      sel_trig ? {4'h0, trig_sel_ff} :
      sel_sts  ? {7'h00, done_sts_ff} :
      sel_en   ? {7'h00, done_en_ff} : 8'h00;

  // ========================================================================
  // Trigger source select and edge detect
  // Level of the selected source; reserved codes give none
  logic trig_level;
  always_comb begin
    case (trig_sel_ff)
      `TRIG_NONE:        trig_level = 1'b0;
      `TRIG_RESULT_READ: trig_level = i_rd & sel_hi;
      default: begin
        if (trig_sel_ff >= `TRIG_PIN && trig_sel_ff <= `TRIG_IOC) begin
          trig_level = trig_sync[4'(trig_sel_ff - `TRIG_PIN)];
        end else begin
          trig_level = 1'b0;
        end
      end
    endcase
  end
  // Read trigger is itself a one-cycle pulse; others need a rising edge
  wire trig_is_read = (trig_sel_ff == `TRIG_RESULT_READ);
  wire trig_event   = trig_is_read ? trig_level : (trig_level & ~trig_prev_ff);

  // ========================================================================
  // Conversion clock: RC clock edge or oscillator divided by 2..64
  // Last count of the divider for each clock code
  logic [5:0] div_last;
  always_comb begin
    case (clk_sel_ff)
      3'b000:  div_last = 6'd1;
      3'b001:  div_last = 6'd7;
      3'b100:  div_last = 6'd3;
      3'b110:  div_last = 6'd63;
      3'b101:  div_last = 6'd15;
      3'b010:  div_last = 6'd31;
      default: div_last = 6'd0;
    endcase
  end
  wire use_rc   = (clk_sel_ff == 3'b111) || (clk_sel_ff == 3'b011);
  wire rc_edge  = rc_s2_ff & ~rc_prev_ff;
  wire div_wrap = (div_cnt_ff == div_last);
  wire tick     = use_rc ? rc_edge : div_wrap;
  assign o_conv_tick = tick & (state_ff == ST_CONVERT);

  // ========================================================================
  // Conversion sequencer
  // Enable as it will stand after this edge; clearing it aborts at once
  wire nxt_enable = wr_a ? i_wdata[`CTLA_ENABLE_BIT] : enable_ff;
  wire sw_start   = wr_a & i_wdata[`CTLA_BUSY_BIT] & enable_ff;
  // A start seen while converting is dropped, not queued
  wire start      = enable_ff & (state_ff != ST_CONVERT) & (sw_start | trig_event);
  wire finish     = (state_ff == ST_CONVERT) & i_core_done;

  // Next state; a cleared enable sends every state to rest
  always_comb begin
    case (state_ff)
      ST_OFF:     nxt_state = !nxt_enable ? ST_OFF : (start ? ST_CONVERT : ST_IDLE);
      ST_IDLE:    nxt_state = !nxt_enable ? ST_OFF : (start ? ST_CONVERT : ST_IDLE);
      ST_CONVERT: nxt_state = !nxt_enable ? ST_OFF : (finish ? ST_IDLE : ST_CONVERT);
      default:    nxt_state = ST_OFF;
    endcase
  end

  // Justified result from the core
  wire [15:0] just_result = format_ff ? {6'h00, i_core_data}
                                      : {i_core_data, 6'h00};

  // Write path of the result bytes when no completion is loading it
  wire [15:0] nxt_result =
      finish           ? just_result :
      (i_wr & sel_hi)  ? {i_wdata, result_ff[7:0]} :
      (i_wr & sel_lo)  ? {result_ff[15:8], i_wdata} : result_ff;

  // Busy bit: set on start, cleared by completion or disable
  wire nxt_busy = (start | (busy_ff & (state_ff == ST_CONVERT)))
                & ~finish & nxt_enable;

  // Done flag: set wins over a clear in the same cycle
  wire clr_done = i_wr & sel_clr & i_wdata[0];
  wire nxt_done = finish | (done_sts_ff & ~clr_done);

  // ========================================================================
  // Core control outputs
  // Implemented analog inputs; every other code routes nothing
  wire chan_ok = (chan_ff <= 6'h05 && chan_ff != 6'h03)
              || (chan_ff >= 6'h0D && chan_ff <= 6'h0F)
              || (chan_ff >= 6'h12 && chan_ff <= 6'h15)
              || (chan_ff == `CHAN_GROUND) || (chan_ff == `CHAN_FIXED_REF);
  // Positive reference decode; the reserved code connects none
  pos_ref_e ref_map;
  always_comb begin
    case (ref_sel_ff)
      2'b11:   ref_map = REF_FIXED;
      2'b10:   ref_map = REF_EXT_PIN;
      2'b00:   ref_map = REF_SUPPLY;
      default: ref_map = REF_NONE;
    endcase
  end
  // Control bundle towards the sampling core
  assign o_core_ctrl = '{enable:        enable_ff,
                         start:         busy_ff,
                         channel:       chan_ok ? chan_ff : 6'h00,
                         channel_valid: chan_ok,
                         pos_ref:       ref_map,
                         use_rc_clock:  use_rc};
  assign o_rdata = rdata_ff;
  assign o_irq   = done_sts_ff & done_en_ff;

  // ========================================================================
  // Two-flop synchroniser per trigger input; only the second flop is read
  for (genvar g = 0; g < N_TRIG; g++) begin : g_trig_sync
    logic s1_ff;
    logic s2_ff;
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
      end else begin
        s1_ff <= i_trig_src[g];
        s2_ff <= s1_ff;
      end
    end
    assign trig_sync[g] = s2_ff;
  end

  // Synchroniser and edge history of the RC clock
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rc_s1_ff   <= 2'b00;
      rc_s2_ff   <= 1'b0;
      rc_prev_ff <= 1'b0;
    end else begin
      rc_s1_ff   <= {rc_s1_ff[0], i_rc_clock};
      rc_s2_ff   <= rc_s1_ff[1];
      rc_prev_ff <= rc_s2_ff;
    end
  end

  // Control register A: channel and enable
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      chan_ff   <= 6'(`RST_CONTROL_A >> `CTLA_CHAN_LSB);
      enable_ff <= 1'b0;
    end else if (wr_a) begin
      chan_ff   <= i_wdata[`CTLA_CHAN_MSB:`CTLA_CHAN_LSB];
      enable_ff <= nxt_enable;
    end
  end

  // Control register B: format, conversion clock and reference
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      format_ff  <= 1'b0;
      clk_sel_ff <= 3'b000;
      ref_sel_ff <= 2'b00;
    end else if (i_wr & sel_b) begin
      format_ff  <= i_wdata[`CTLB_FORMAT_BIT];
      clk_sel_ff <= i_wdata[`CTLB_CLK_MSB:`CTLB_CLK_LSB];
      ref_sel_ff <= i_wdata[`CTLB_REF_MSB:`CTLB_REF_LSB];
    end
  end

  // Trigger select and interrupt enable
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      trig_sel_ff <= `RST_TRIGGER_SEL;
      done_en_ff  <= 1'b0;
    end else if (i_wr) begin
      if (sel_trig) begin
        trig_sel_ff <= i_wdata[`TRIG_MSB:`TRIG_LSB];
      end else if (sel_en) begin
        done_en_ff <= i_wdata[0];
      end
    end
  end

  // Sequencer state and busy bit
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= ST_OFF;
      busy_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff  <= nxt_busy;
    end
  end

  // Result register and done flag
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      result_ff   <= `RST_RESULT;
      done_sts_ff <= 1'b0;
    end else begin
      result_ff   <= nxt_result;
      done_sts_ff <= nxt_done;
    end
  end

  // Read data stands one cycle after the strobe; trigger level history
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_ff     <= 8'h00;
      trig_prev_ff <= 1'b0;
    end else begin
      rdata_ff     <= i_rd ? rd_mux : 8'h00;
      trig_prev_ff <= trig_level;
    end
  end

  // Oscillator divider, running only during a conversion
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_cnt_ff <= 6'd0;
    end else begin
      div_cnt_ff <= (div_wrap || state_ff != ST_CONVERT) ? 6'd0 : div_cnt_ff + 6'd1;
    end
  end

endmodule : adc_control_register_logic

//--- sim/adc_control_register_logic_properties.sv
// Port-level checker of the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_control_register_logic_properties
  import adc_ctrl_pkg::*;
(
  input wire logic       i_ref_clk,
  input wire logic       i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_core_done,
  input wire core_ctrl_s o_core_ctrl,
  input wire logic       o_conv_tick,
  input wire logic       o_irq
);
  // ==========================================================================
  // Decodes
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  wire wr_a  = i_wr && i_addr == `OFS_CONTROL_A;
  wire wr_b  = i_wr && i_addr == `OFS_CONTROL_B;
  wire wr_ie = i_wr && i_addr == `OFS_IRQ_ENABLE;
  wire fin   = o_core_ctrl.start && i_core_done;
  wire idle  = o_core_ctrl.enable && !o_core_ctrl.start;

  // ==========================================================================
  // Properties
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_start_en; o_core_ctrl.start |-> o_core_ctrl.enable; endproperty
  a_start_en: assert property (p_start_en) else $error("busy while disabled");
  property p_sw_start; wr_a && i_wdata[1:0] == 2'b11 && idle |=> o_core_ctrl.start; endproperty
  a_sw_start: assert property (p_sw_start) else $error("start write lost");
  property p_done; fin |=> !o_core_ctrl.start; endproperty
  a_done: assert property (p_done) else $error("busy not cleared");
  property p_irq_rise; $rose(o_irq) |-> $past(fin) || $past(wr_ie); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt without cause");
  property p_tick; o_conv_tick |-> o_core_ctrl.start; endproperty
  a_tick: assert property (p_tick) else $error("tick outside conversion");
  property p_ref;
    wr_b && i_wdata[1:0] == 2'b11 && o_core_ctrl.enable |=> o_core_ctrl.pos_ref == REF_FIXED;
  endproperty
  a_ref: assert property (p_ref) else $error("reference not fixed");
  property p_chan;
    wr_a && i_wdata[7:2] == `CHAN_GROUND && i_wdata[0]
      |=> o_core_ctrl.channel == `CHAN_GROUND && o_core_ctrl.channel_valid;
  endproperty
  a_chan: assert property (p_chan) else $error("ground channel not routed");
  property p_resv; !o_core_ctrl.channel_valid |-> o_core_ctrl.channel == 6'h00; endproperty
  a_resv: assert property (p_resv) else $error("reserved channel routed");
  c_done: cover property (fin);
  c_irq: cover property ($rose(o_irq));
  c_tick: cover property (o_conv_tick);
endmodule : adc_control_register_logic_properties

bind adc_control_register_logic adc_control_register_logic_properties u_props (
  .i_ref_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_core_done, .o_core_ctrl, .o_conv_tick, .o_irq
);

//--- sim/adc_core_model.sv
// Behavioural model of the analog sampling and conversion core
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_core_model
  import adc_ctrl_pkg::*;
#(
  parameter logic [9:0] SAMPLE = 10'h2A5
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  input  wire core_ctrl_s i_ctrl,
  input  wire logic       i_tick,
  output logic            o_done,
  output logic [9:0]      o_data
);
  // ==========================================================================
  // Conversion timing
  logic [7:0] ticks_ff;
  wire        last = i_ctrl.start && !o_done && ticks_ff == `CONV_TICKS;

  // Count conversion ticks, finish after the full conversion length
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ticks_ff <= 8'h00;
      o_done   <= 1'b0;
    end else begin
      ticks_ff <= (!i_ctrl.start || last) ? 8'h00 : ticks_ff + 8'(i_tick);
      o_done   <= last;
    end
  end
  // Data valid only beside done; inverted otherwise so stale use shows
  assign o_data = o_done ? SAMPLE : ~SAMPLE;
endmodule : adc_core_model

//--- sim/tb_adc_control_register_logic.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module tb_adc_control_register_logic import adc_ctrl_pkg::*;;
  // ==========================================================================
  // Signals and instances
  logic        ref_clk, rst_b, wr_stb, rd_stb, rc_clock, core_done, conv_tick, irq;
  logic [7:0]  addr, wdata, rdata;
  logic [8:0]  trig_src;
  logic [9:0]  core_data;
  logic [15:0] res;
  core_ctrl_s  core_ctrl;
  int          n_fail, n_compared, cycles, rc_cnt;
  localparam logic [15:0] SMP = 16'h02A5;
  pos_ref_e    ref_exp [4] = '{REF_SUPPLY, REF_NONE, REF_EXT_PIN, REF_FIXED};
  int          div_exp [8] = '{2, 8, 32, 10, 4, 16, 64, 10};
  logic [7:0]  regs [7] = '{8'h9B, 8'h9C, 8'h9D, 8'h9E, 8'h9F, 8'hA0, 8'h50};

  adc_control_register_logic DUT (
    .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_stb), .i_rd(rd_stb), .o_rdata(rdata), .i_rc_clock(rc_clock),
    .i_trig_src(trig_src), .i_core_done(core_done), .i_core_data(core_data),
    .o_core_ctrl(core_ctrl), .o_conv_tick(conv_tick), .o_irq(irq));
  adc_core_model u_core (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_ctrl(core_ctrl),
    .i_tick(conv_tick), .o_done(core_done), .o_data(core_data));

  // Clock, RC clock of ten cycles, and hang limit
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    rc_cnt   <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
    rc_clock <= (rc_cnt == 4) ? ~rc_clock : rc_clock;
    cycles   <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    #1;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : reg_rd
  // Start by software, measure tick spacing, wait for the end
  task automatic convert(input logic [7:0] cb);
    int n, t1, t2;
    reg_wr(`OFS_CONTROL_B, cb);
    chk(core_ctrl.use_rc_clock, cb[5:4] == 2'b11);
    reg_wr(`OFS_CONTROL_A, 8'h03);
    reg_rd(`OFS_CONTROL_A, 8'h03);
    n = 0;
    t1 = 0;
    t2 = 0;
    while (core_ctrl.start === 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (conv_tick === 1'b1) begin
        t1 = t2;
        t2 = n;
      end
    end
    if (cb != 8'h00) chk(16'(t2 - t1), 16'(div_exp[cb[6:4]]));
    reg_rd(`OFS_CONTROL_A, 8'h01);
  endtask : convert
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // ==========================================================================
  // Test sequence
  initial begin
    {rst_b, wr_stb, rd_stb, rc_clock, trig_src, addr, wdata} = '0;
    {n_fail, n_compared, cycles, rc_cnt} = '0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (regs[i]) reg_rd(regs[i], 8'h00);
    reg_wr(`OFS_RESULT_LOW, 8'h5A);
    reg_wr(`OFS_RESULT_HIGH, 8'hC3);
    reg_rd(`OFS_RESULT_LOW, 8'h5A);
    reg_rd(`OFS_RESULT_HIGH, 8'hC3);
    $display("test registers finished");
    reg_wr(`OFS_CONTROL_A, 8'h03);
    chk({core_ctrl.enable, core_ctrl.start}, 2'b10);
    reg_wr(`OFS_CONTROL_A, 8'h91);
    chk({core_ctrl.channel_valid, core_ctrl.channel}, {1'b1, `CHAN_GROUND});
    reg_wr(`OFS_CONTROL_A, 8'h0D);
    chk({core_ctrl.channel_valid, core_ctrl.channel}, 7'h00);
    reg_wr(`OFS_CONTROL_A, 8'h95);
    reg_rd(`OFS_CONTROL_A, 8'h95);
    chk({core_ctrl.channel_valid, core_ctrl.channel}, {1'b1, `CHAN_FIXED_REF});
    for (int r = 0; r < 4; r++) begin
      reg_wr(`OFS_CONTROL_B, 8'(r));
      chk(core_ctrl.pos_ref, ref_exp[r]);
    end
    $display("test routing finished");
    reg_wr(`OFS_CONTROL_A, 8'h01);
    for (int c = 0; c < 8; c++) begin
      convert({c[0], c[2:0], 4'h0});
      res = c[0] ? SMP : SMP << 6;
      reg_rd(`OFS_RESULT_HIGH, res[15:8]);
      reg_rd(`OFS_RESULT_LOW, res[7:0]);
    end
    reg_rd(`OFS_IRQ_STATUS, 8'h01);
    chk(irq, 1'b0);
    reg_wr(`OFS_IRQ_ENABLE, 8'h01);
    chk(irq, 1'b1);
    reg_wr(`OFS_IRQ_CLEAR, 8'h01);
    chk(irq, 1'b0);
    $display("test conversions finished");
    for (int k = 0; k < 10; k++) begin
      reg_wr(`OFS_TRIGGER_SEL, 8'(k));
      trig_src <= 9'(k == 0 ? 1 : 1 << (k - 1));
      repeat (6) @(posedge ref_clk);
      trig_src <= 8'h00;
      #1;
      chk(core_ctrl.start, k != 0);
      convert(8'h00);
    end
    reg_wr(`OFS_TRIGGER_SEL, 8'h0D);
    reg_rd(`OFS_RESULT_HIGH, SMP[9:2]);
    chk(core_ctrl.start, 1'b1);
    reg_wr(`OFS_CONTROL_A, 8'h00);
    chk({core_ctrl.enable, core_ctrl.start}, 2'b00);
    $display("test triggers finished");
    end_sim();
  end
endmodule : tb_adc_control_register_logic
